// ===== design/sapi_adc_ctrl.v
// Converter control, result latch and parallel readout
//
// Contract
// RL1: Conversion timing comes from the local clock; no host clock used.
// RL2: Host holds trigger low 20 ns with chip select low to start.
// RL3: Trigger falling edge ends sampling and freezes the input value.
// RL4: Busy rises after trigger falls and stays high until conversion ends.
// RL5: Sampling starts at once with select low, else at its fall.
// RL6: Strobe and select may stay high; select low needed at trigger.
// RL7: Bus driven only with select and strobe both low, else released.
// RL8: Host reads nothing from 50 ns before to 40 ns after trigger.
// RL9: Result is two's complement, 7fff top, 8000 bottom.
// RL10: Half select low puts whole word on the bus, msb on top.
// RL11: Half select high puts low byte on top lanes, ones below.
// RL12: Byte host reads high byte first, then low byte, top lanes.
// RL13: Byte reads work with strobe pulsed or held low throughout.
// RL14: Reset pin is active low, independent of select, held 25 ns.
// RL15: Reset aborts a running conversion within 50 ns.
// RL16: Reset clears the output result latch to zero.
// RL17: Normal work resumes, sampling starts, 20 ns after reset release.
// RL18: Sampling restarts at later of busy fall and select fall.
// RL19: Trigger during conversion with select low starts self reset.
// RL20: Power-up resets itself; three conversions before all is clear.
// RL21: Each conversion takes 400 ns for 2 MHz throughput; here a full FIFO stretches it until a slot frees.
// RL22: Host allows 100 ns of sampling before the next trigger.
// RL23: Finished result is latched and held until next result or reset.
`timescale 1ns/1ns
`include "sapi_defines.vh"
module sapi_adc_ctrl (
   // Clock and power-on reset
   input  wire        REF_CLK,
   input  wire        RST,
   // Host control pins
   input  wire        RESET_N,
   input  wire        CONV_TRIG_N,
   input  wire        CHIP_SEL_N,
   input  wire        READ_STROBE_N,
   input  wire        HALF_SELECT,
   // Held analog value, as signed code
   input  wire [15:0] ANALOG_IN,
   // Status
   output wire        BUSY,
   output wire        SAMPLING,
   output wire        PRIMED,
   output wire        TRIG_SHORT,
   output wire        ACQ_SHORT,
   output wire        QUIET_VIOL,
   // Result bus
   output wire [15:0] RESULT_BUS_LANES_O,
   output wire        RESULT_BUS_LANES_OE_N
);
   localparam [1:0] ST_RECOV  = 2'd0;
   localparam [1:0] ST_WAIT   = 2'd1;
   localparam [1:0] ST_SAMPLE = 2'd2;
   localparam [1:0] ST_CONV   = 2'd3;

   // Cycle counts, cut to the counter width on purpose
   localparam integer CONV_I  = `SAPI_CONV_CYC;
   localparam integer RECOV_I = `SAPI_RECOV_CYC;
   localparam integer ACQ_I   = `SAPI_ACQ_CYC;
   localparam integer TRIG_I  = `SAPI_TRIG_CYC;
   localparam integer PRE_I   = `SAPI_PRE_CYC;
   localparam integer POST_I  = `SAPI_POST_CYC;
   localparam integer STEPS_I = `SAPI_SAR_STEPS;

   localparam [5:0] CONV_CYC  = CONV_I[5:0];
   localparam [5:0] RECOV_CYC = RECOV_I[5:0];
   localparam [5:0] ACQ_CYC   = ACQ_I[5:0];
   localparam [5:0] TRIG_CYC  = TRIG_I[5:0];
   localparam [5:0] PRE_CYC   = PRE_I[5:0];
   localparam [5:0] POST_CYC  = POST_I[5:0];
   localparam [5:0] SAR_STEPS = STEPS_I[5:0];

   // Saturating increment of a cycle counter
   function [5:0] sat_inc;
      input [5:0] v;
      begin
         if (v == 6'h3f) begin
            sat_inc = v;
         end else begin
            sat_inc = v + 6'h01;
         end
      end
   endfunction

   reg  [1:0]  state_q;
   reg  [1:0]  state_d;
   reg  [5:0]  cnt_q;
   reg  [5:0]  cnt_d;
   reg         busy_q;
   reg         busy_d;
   reg         trig_q;
   reg         cs_q;
   reg  [5:0]  trig_low_q;
   reg  [5:0]  acq_q;
   reg  [5:0]  since_rd_q;
   reg  [5:0]  since_trig_q;
   reg         trig_short_q;
   reg         acq_short_q;
   reg         quiet_q;
   reg  [1:0]  prime_q;
   reg  [15:0] latch_q;
   reg  [15:0] bus_q;
   reg         push;
   reg         sar_start;

   wire        cs_low;
   wire        reading;
   wire        trig_fall;
   wire        trig_rise;
   wire        cs_fall;
   wire        in_conv;
   wire        in_sample;
   wire        start;
   wire        abort;
   wire        clr;
   wire        sar_step;
   wire [15:0] sar_result;
   wire        fifo_in_ready;
   wire        fifo_out_valid;
   wire [15:0] fifo_out_data;
   wire        fifo_out_ready;

   assign cs_low    = ~CHIP_SEL_N;
   assign reading   = cs_low & ~READ_STROBE_N;
   assign trig_fall = trig_q & ~CONV_TRIG_N;
   assign trig_rise = ~trig_q & CONV_TRIG_N;
   assign cs_fall   = cs_q & cs_low;
   assign in_conv   = (state_q == ST_CONV);
   assign in_sample = (state_q == ST_SAMPLE);
   // Trigger counts only with select low
   assign start     = trig_fall & cs_low; // RL6
   // Trigger while converting aborts like the pin
   assign abort     = start & in_conv; // RL19
   assign clr       = ~RESET_N | abort; // RL14 RL15
   assign sar_step  = in_conv & (cnt_q < SAR_STEPS);

   // Edge history of host pins
   always @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         trig_q <= 1'b1;
         cs_q   <= 1'b1;
      end else begin
         trig_q <= CONV_TRIG_N;
         cs_q   <= CHIP_SEL_N;
      end
   end

   // Conversion sequencer, timed by the local clock only
   always @* begin // RL1
      state_d   = state_q;
      cnt_d     = cnt_q;
      busy_d    = busy_q;
      push      = 1'b0;
      sar_start = 1'b0;
      case (state_q)
         ST_RECOV: begin
            cnt_d = cnt_q + 6'h01;
            // First sampling period after release
            if (cnt_q == RECOV_CYC - 6'h01) begin
               state_d = ST_SAMPLE; // RL17
               cnt_d   = 6'h00;
            end
         end
         ST_WAIT: begin
            if (start) begin
               state_d   = ST_CONV;
               cnt_d     = 6'h00;
               busy_d    = 1'b1;
               sar_start = 1'b1;
            end else if (cs_fall) begin
               state_d = ST_SAMPLE; // RL5 RL18
            end
         end
         ST_SAMPLE: begin
            if (start) begin
               state_d   = ST_CONV; // RL3
               cnt_d     = 6'h00;
               busy_d    = 1'b1; // RL4
               sar_start = 1'b1;
            end
         end
         default: begin
            if (cnt_q == CONV_CYC - 6'h01) begin // RL21
               // Full FIFO stalls the end of conversion
               if (fifo_in_ready) begin
                  push   = 1'b1;
                  busy_d = 1'b0; // RL4
                  if (cs_low) begin
                     state_d = ST_SAMPLE; // RL5
                  end else begin
                     state_d = ST_WAIT; // RL18
                  end
               end
            end else begin
               cnt_d = cnt_q + 6'h01;
            end
         end
      endcase
   end

   always @(posedge REF_CLK or posedge RST) begin // RL20
      if (RST) begin
         state_q <= ST_RECOV;
         cnt_q   <= 6'h00;
         busy_q  <= 1'b0;
      end else if (clr) begin
         // Held here while the pin is low, one cycle on a self reset
         state_q <= ST_RECOV; // RL15 RL19
         cnt_q   <= 6'h00;
         busy_q  <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         busy_q  <= busy_d;
      end
   end

   sapi_sar u_sar (
      .clk       (REF_CLK),
      .rst       (RST),
      .clr       (clr),
      .start     (sar_start), // RL3
      .step      (sar_step),
      .sample_in (ANALOG_IN),
      .result    (sar_result) // RL9
   );

   // Drain stalls while the host is reading the latch
   assign fifo_out_ready = ~reading; // RL13

   sapi_fifo #(
      .W  (`SAPI_RES_W),
      .D  (`SAPI_FIFO_D),
      .AW (`SAPI_FIFO_AW)
   ) u_fifo (
      .clk       (REF_CLK),
      .rst       (RST),
      .clr       (clr),
      .in_valid  (push),
      .in_ready  (fifo_in_ready),
      .in_data   (sar_result),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_out_ready),
      .out_data  (fifo_out_data)
   );

   // Output latch and registered bus data
   always @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         latch_q <= `SAPI_RESULT_RST;
         bus_q   <= `SAPI_RESULT_RST;
      end else begin
         if (clr) begin
            latch_q <= `SAPI_RESULT_RST; // RL16
         end else if (fifo_out_valid & fifo_out_ready) begin
            latch_q <= fifo_out_data; // RL23
         end
         if (HALF_SELECT) begin
            bus_q <= {latch_q[7:0], `SAPI_LOW_FILL}; // RL11 RL12
         end else begin
            bus_q <= latch_q; // RL10
         end
      end
   end

   assign RESULT_BUS_LANES_O    = bus_q;
   assign RESULT_BUS_LANES_OE_N = ~reading; // RL7

   // Power-on priming over three completed conversions
   always @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         prime_q <= 2'd0;
      end else if (push & (prime_q != `SAPI_PRIME_CONV)) begin
         prime_q <= prime_q + 2'd1; // RL20
      end
   end

   // Host timing monitors
   always @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         trig_low_q   <= 6'h00;
         acq_q        <= 6'h00;
         since_rd_q   <= 6'h3f;
         since_trig_q <= 6'h3f;
      end else begin
         if (trig_fall) begin
            trig_low_q <= 6'h01;
         end else if (~CONV_TRIG_N) begin
            trig_low_q <= sat_inc(trig_low_q);
         end
         if (state_q == ST_SAMPLE) begin
            acq_q <= sat_inc(acq_q);
         end else begin
            acq_q <= 6'h00;
         end
         if (reading) begin
            since_rd_q <= 6'h00;
         end else begin
            since_rd_q <= sat_inc(since_rd_q);
         end
         if (trig_fall) begin
            since_trig_q <= 6'h00;
         end else begin
            since_trig_q <= sat_inc(since_trig_q);
         end
      end
   end

   // Sticky violation flags, cleared by either reset
   always @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         trig_short_q <= 1'b0;
         acq_short_q  <= 1'b0;
         quiet_q      <= 1'b0;
      end else begin
         if (trig_rise & (trig_low_q < TRIG_CYC)) begin
            trig_short_q <= 1'b1; // RL2
         end else if (~RESET_N) begin
            trig_short_q <= 1'b0;
         end
         if (start & (state_q == ST_SAMPLE) & (acq_q < ACQ_CYC)) begin
            acq_short_q <= 1'b1; // RL22
         end else if (~RESET_N) begin
            acq_short_q <= 1'b0;
         end
         if ((trig_fall & (since_rd_q < PRE_CYC)) |
             (reading & (since_trig_q < POST_CYC))) begin
            quiet_q <= 1'b1; // RL8
         end else if (~RESET_N) begin
            quiet_q <= 1'b0;
         end
      end
   end

   assign BUSY       = busy_q;
   assign SAMPLING   = in_sample;
   assign PRIMED     = (prime_q == `SAPI_PRIME_CONV);
   assign TRIG_SHORT = trig_short_q;
   assign ACQ_SHORT  = acq_short_q;
   assign QUIET_VIOL = quiet_q;
endmodule // sapi_adc_ctrl

// ===== design/sapi_defines.vh
// Constants of the converter control and readout block
`ifndef SAPI_DEFINES_VH
`define SAPI_DEFINES_VH

`define SAPI_CLK_NS       10
`define SAPI_T_CONV_NS    400
`define SAPI_T_RECOV_NS   20
`define SAPI_T_ACQ_NS     100
`define SAPI_T_TRIG_NS    20
`define SAPI_T_PRE_NS     50
`define SAPI_T_POST_NS    40

// Longest times round down, least times round up
`define SAPI_CONV_CYC  (`SAPI_T_CONV_NS / `SAPI_CLK_NS)
`define SAPI_RECOV_CYC (`SAPI_T_RECOV_NS / `SAPI_CLK_NS)
`define SAPI_ACQ_CYC   ((`SAPI_T_ACQ_NS + `SAPI_CLK_NS - 1) / `SAPI_CLK_NS)
`define SAPI_TRIG_CYC  ((`SAPI_T_TRIG_NS + `SAPI_CLK_NS - 1) / `SAPI_CLK_NS)
`define SAPI_PRE_CYC   ((`SAPI_T_PRE_NS + `SAPI_CLK_NS - 1) / `SAPI_CLK_NS)
`define SAPI_POST_CYC  ((`SAPI_T_POST_NS + `SAPI_CLK_NS - 1) / `SAPI_CLK_NS)

`define SAPI_PRIME_CONV   2'd3
`define SAPI_RES_W        16
`define SAPI_SAR_STEPS    16
`define SAPI_FIFO_D       8
`define SAPI_FIFO_AW      3
`define SAPI_MSB_FLIP     16'h8000
`define SAPI_LOW_FILL     8'hff
`define SAPI_RESULT_RST   16'h0000

`endif

// ===== design/sapi_fifo.v
// Result FIFO with registered read data
`timescale 1ns/1ns
module sapi_fifo #(
   parameter W  = 16,
   parameter D  = 8,
   parameter AW = 3
) (
   // Clock and reset
   input  wire         clk,
   input  wire         rst,
   input  wire         clr,
   // Fill side
   input  wire         in_valid,
   output wire         in_ready,
   input  wire [W-1:0] in_data,
   // Drain side
   output wire         out_valid,
   input  wire         out_ready,
   output wire [W-1:0] out_data
);
   reg  [W-1:0] mem [0:D-1];
   reg  [AW-1:0] wr_q;
   reg  [AW-1:0] rd_q;
   reg  [AW:0]   cnt_q;
   reg  [W-1:0]  out_q;
   reg           ov_q;
   wire          push;
   wire          load;

   assign in_ready  = (cnt_q != D[AW:0]);
   assign push      = in_valid & in_ready;
   // Head moves into the output register when it is free
   assign load      = (cnt_q != {(AW+1){1'b0}}) & (~ov_q | out_ready);
   assign out_valid = ov_q;
   assign out_data  = out_q;

   always @(posedge clk) begin
      if (push) begin
         mem[wr_q] <= in_data;
      end
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_q  <= {AW{1'b0}};
         rd_q  <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
         out_q <= {W{1'b0}};
         ov_q  <= 1'b0;
      end else if (clr) begin
         wr_q  <= {AW{1'b0}};
         rd_q  <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
         ov_q  <= 1'b0;
      end else begin
         if (push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (load) begin
            rd_q  <= rd_q + 1'b1;
            out_q <= mem[rd_q];
            ov_q  <= 1'b1;
         end else if (out_ready) begin
            ov_q <= 1'b0;
         end
         if (push & ~load) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (load & ~push) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
endmodule // sapi_fifo

// ===== design/sapi_sar.v
// Successive approximation register and sample hold
`timescale 1ns/1ns
`include "sapi_defines.vh"
module sapi_sar (
   // Clock and reset
   input  wire        clk,
   input  wire        rst,
   input  wire        clr,
   // Control
   input  wire        start,
   input  wire        step,
   input  wire [15:0] sample_in,
   // Result, two's complement
   output wire [15:0] result
);
   reg  [15:0] held_q;
   reg  [15:0] trial_q;
   reg  [15:0] mask_q;
   wire [15:0] probe;

   assign probe  = trial_q | mask_q;
   assign result = trial_q ^ `SAPI_MSB_FLIP;

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         held_q  <= 16'h0000;
         trial_q <= 16'h0000;
         mask_q  <= 16'h0000;
      end else if (clr) begin
         trial_q <= 16'h0000;
         mask_q  <= 16'h0000;
      end else if (start) begin
         // Offset binary so unsigned compare orders codes
         held_q  <= sample_in ^ `SAPI_MSB_FLIP;
         trial_q <= 16'h0000;
         mask_q  <= `SAPI_MSB_FLIP;
      end else if (step) begin
         if (probe <= held_q) begin
            trial_q <= probe;
         end
         mask_q <= {1'b0, mask_q[15:1]};
      end
   end
endmodule // sapi_sar

// ===== verif/sapi_adc_ctrl_properties.sv
// Port checks for the converter control block
`timescale 1ns/1ns
module sapi_chk (
   // Clock and reset
   input wire        REF_CLK,
   input wire        RST,
   // Host pins
   input wire        RESET_N,
   input wire        CONV_TRIG_N,
   input wire        CHIP_SEL_N,
   input wire        READ_STROBE_N,
   input wire        HALF_SELECT,
   // Status and bus
   input wire        BUSY,
   input wire        SAMPLING,
   input wire [15:0] RESULT_BUS_LANES_O,
   input wire        RESULT_BUS_LANES_OE_N
);
   localparam [7:0] CONV = 8'h28;
   reg       trig_q;
   reg [7:0] bcnt_q;
   wire      abort = trig_q & ~CONV_TRIG_N & ~CHIP_SEL_N & BUSY;
   always @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         trig_q <= 1'b1;
         bcnt_q <= 8'h00;
      end else begin
         trig_q <= CONV_TRIG_N;
         bcnt_q <= BUSY ? bcnt_q + 8'h01 : 8'h00;
      end
   end
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (RST);
   a_bus_enable: assert property (
      RESULT_BUS_LANES_OE_N == (CHIP_SEL_N | READ_STROBE_N))
      else $error("bus enable wrong");
   a_busy_start: assert property (
      $fell(CONV_TRIG_N) && !CHIP_SEL_N && SAMPLING && RESET_N |=> BUSY)
      else $error("busy not raised");
   a_busy_cause: assert property (
      $rose(BUSY) |-> $past(!CONV_TRIG_N && !CHIP_SEL_N))
      else $error("busy without trigger");
   a_conv_time: assert property (
      $fell(BUSY) && $past(RESET_N) && !$past(abort) |-> bcnt_q >= CONV)
      else $error("conversion too short");
   a_reset_abort: assert property (
      !RESET_N |=> !BUSY)
      else $error("reset left busy");
   a_self_abort: assert property (
      abort && RESET_N |=> !BUSY && !SAMPLING)
      else $error("self reset missed");
   a_recov_time: assert property (
      $rose(RESET_N) && !CHIP_SEL_N |-> ##[2:3] SAMPLING)
      else $error("sampling late after reset");
   a_latch_clear: assert property (
      !RESET_N && !HALF_SELECT ##1 !HALF_SELECT
      |=> RESULT_BUS_LANES_O == 16'h0000)
      else $error("latch not cleared");
   a_byte_fill: assert property (
      HALF_SELECT |=> RESULT_BUS_LANES_O[7:0] == 8'hff)
      else $error("low lanes not ones");
   a_read_hold: assert property (
      RESET_N && !RESULT_BUS_LANES_OE_N ##1 RESET_N
      && !RESULT_BUS_LANES_OE_N && $stable(HALF_SELECT)
      |=> $stable(RESULT_BUS_LANES_O))
      else $error("data moved during read");
   c_abort: cover property (abort);
   c_stall: cover property (bcnt_q > 8'h29);
   c_byte: cover property (HALF_SELECT && !RESULT_BUS_LANES_OE_N);
endmodule // sapi_chk

bind sapi_adc_ctrl sapi_chk u_chk (.REF_CLK(REF_CLK), .RST(RST),
   .RESET_N(RESET_N), .CONV_TRIG_N(CONV_TRIG_N), .CHIP_SEL_N(CHIP_SEL_N),
   .READ_STROBE_N(READ_STROBE_N), .HALF_SELECT(HALF_SELECT), .BUSY(BUSY),
   .SAMPLING(SAMPLING), .RESULT_BUS_LANES_O(RESULT_BUS_LANES_O),
   .RESULT_BUS_LANES_OE_N(RESULT_BUS_LANES_OE_N));

// ===== verif/sapi_host_bus.sv
// Host view of the three-state result bus
`timescale 1ns/1ns
module sapi_host_bus (
   // Device side
   input  wire [15:0] lanes_o,
   input  wire        lanes_oe_n,
   // Host side
   output wire [15:0] lanes
);
   reg [15:0] last_q = 16'h0000;
   always @*
      if (!lanes_oe_n)
         last_q = lanes_o;
   // Released bus shows no stale data
   assign lanes = lanes_oe_n ? ~last_q : lanes_o;
endmodule // sapi_host_bus

// ===== verif/tb_sar_adc_parallel_interface.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ns
module tb_sar_adc_parallel_interface;
   reg          ref_clk = 1'b0;
   reg          rst     = 1'b1;
   reg          reset_n = 1'b1;
   reg          trig_n  = 1'b1;
   reg          cs_n    = 1'b0;
   reg          rd_n    = 1'b1;
   reg          hs      = 1'b0;
   reg          look    = 1'b0;
   reg   [15:0] ain     = 16'h0000;
   reg   [15:0] v;
   reg   [15:0] codes [0:3];
   logic [15:0] exp_q [$];
   wire         busy;
   wire         smp;
   wire         primed;
   wire         tshort;
   wire         ashort;
   wire         quiet;
   wire         oe_n;
   wire  [15:0] lo;
   wire  [15:0] lanes;
   integer      fail_count = 0;
   integer      num_checks = 0;
   integer      seed = 53;
   integer      i;

   always #5 ref_clk = ~ref_clk;

   sapi_adc_ctrl DUT (.REF_CLK(ref_clk), .RST(rst), .RESET_N(reset_n),
      .CONV_TRIG_N(trig_n), .CHIP_SEL_N(cs_n), .READ_STROBE_N(rd_n),
      .HALF_SELECT(hs), .ANALOG_IN(ain), .BUSY(busy), .SAMPLING(smp),
      .PRIMED(primed), .TRIG_SHORT(tshort), .ACQ_SHORT(ashort),
      .QUIET_VIOL(quiet), .RESULT_BUS_LANES_O(lo),
      .RESULT_BUS_LANES_OE_N(oe_n));
   sapi_host_bus u_host (.lanes_o(lo), .lanes_oe_n(oe_n), .lanes(lanes));

   task chk(input [15:0] got, input [15:0] exp);
      begin
         num_checks = num_checks + 1;
         if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
         end
      end
   endtask

   task give_verdict;
      begin
         $display("checks %0d errors %0d", num_checks, fail_count);
         if (fail_count == 0 && num_checks > 0)
            $display("TB: PASS");
         else
            $display("TB: FAIL");
         $finish;
      end
   endtask

   // Bus monitor against the oldest note
   always @(posedge ref_clk)
      if (look)
         chk(lanes, exp_q.pop_front());

   task rd(input [15:0] e, input h, input rel);
      begin
         @(posedge ref_clk);
         cs_n <= 1'b0;
         rd_n <= 1'b0;
         hs   <= h;
         repeat (2) @(posedge ref_clk);
         exp_q.push_back(e);
         look <= 1'b1;
         @(posedge ref_clk);
         look <= 1'b0;
         if (rel)
            rd_n <= 1'b1;
      end
   endtask

   task conv(input [15:0] a, input keep);
      begin
         repeat (10) @(posedge ref_clk);
         cs_n   <= 1'b0;
         ain    <= a;
         trig_n <= 1'b0;
         repeat (2) @(posedge ref_clk);
         trig_n <= 1'b1;
         if (!keep)
            cs_n <= 1'b1;
      end
   endtask

   task wdone(input keep);
      integer n;
      begin
         n = 0;
         while (busy !== 1'b0 && n < 100) begin
            @(negedge ref_clk);
            n = n + 1;
         end
         chk(busy, 1'b0);
         if (!keep) begin
            repeat (2) @(negedge ref_clk);
            chk(smp, 1'b0);
            @(posedge ref_clk);
            cs_n <= 1'b0;
            repeat (3) @(negedge ref_clk);
            chk(smp, 1'b1);
         end
      end
   endtask

   initial begin
      repeat (20000) @(posedge ref_clk);
      fail_count = fail_count + 1;
      give_verdict;
   end

   initial begin
      codes[0] = 16'h7fff;
      codes[1] = 16'h0000;
      codes[2] = 16'hffff;
      codes[3] = 16'h8000;
      repeat (20) @(posedge ref_clk);
      rst <= 1'b0;
      rd(16'h0000, 1'b0, 1'b1);
      for (i = 0; i < 8; i = i + 1) begin
         v = (i < 4) ? codes[i] : $random(seed);
         conv(v, 1'b0);
         wdone(1'b0);
         if (i == 1)
            chk(primed, 1'b0);
         if (i == 2)
            chk(primed, 1'b1);
         rd(v, 1'b0, 1'b1);
         rd({v[7:0], 8'hff}, 1'b1, 1'b1);
         rd(v, 1'b0, 1'b0);
         rd({v[7:0], 8'hff}, 1'b1, 1'b1);
      end
      @(negedge ref_clk);
      chk({tshort, ashort, quiet}, 3'b000);
      // Trigger with select high is ignored, clear of the quiet zone
      repeat (10) @(posedge ref_clk);
      cs_n   <= 1'b1;
      trig_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      trig_n <= 1'b1;
      @(negedge ref_clk);
      chk(busy, 1'b0);
      // Reset pin in mid conversion
      conv(16'h1234, 1'b1);
      repeat (5) @(posedge ref_clk);
      reset_n <= 1'b0;
      hs      <= 1'b0;
      repeat (3) @(posedge ref_clk);
      reset_n <= 1'b1;
      @(negedge ref_clk);
      chk(busy, 1'b0);
      rd(16'h0000, 1'b0, 1'b1);
      conv(16'h5a5a, 1'b0);
      wdone(1'b0);
      rd(16'h5a5a, 1'b0, 1'b1);
      // Second trigger aborts a running conversion
      conv(16'h0f0f, 1'b1);
      repeat (5) @(posedge ref_clk);
      trig_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      trig_n <= 1'b1;
      @(negedge ref_clk);
      chk(busy, 1'b0);
      rd(16'h0000, 1'b0, 1'b1);
      // Held read freezes the latch and fills the buffer
      @(posedge ref_clk);
      rd_n <= 1'b0;
      for (i = 0; i < 10; i = i + 1) begin
         conv(16'h0100 + i[15:0], 1'b1);
         if (i < 9)
            wdone(1'b1);
      end
      repeat (45) @(negedge ref_clk);
      chk(busy, 1'b1);
      @(posedge ref_clk);
      rd_n <= 1'b1;
      wdone(1'b1);
      repeat (30) @(posedge ref_clk);
      rd(16'h0109, 1'b0, 1'b1);
      // One-cycle trigger with select high only raises the flag
      repeat (10) @(posedge ref_clk);
      cs_n   <= 1'b1;
      trig_n <= 1'b0;
      @(posedge ref_clk);
      trig_n <= 1'b1;
      repeat (3) @(negedge ref_clk);
      // Held read above ran through trigger edges on purpose
      chk({tshort, ashort, quiet}, 3'b101);
      repeat (3) @(posedge ref_clk);
      give_verdict;
   end
endmodule // tb_sar_adc_parallel_interface
